// *** hdl/fpx_pkg.sv ***
// Package: shared constants, types and register map of the exception prioritizer
package fpx_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] FLAGS_ADDR = 8'h04;
    localparam logic [7:0] IRQ_STAT_ADDR = 8'h08;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h0C;
    localparam logic [7:0] LAST_ADDR = 8'h10;

    // ----------------------------------------------------------------
    // Exception mask / flag bit positions
    // ----------------------------------------------------------------
    localparam int INV_BIT = 0;
    localparam int DNR_BIT = 1;
    localparam int ZDV_BIT = 2;
    localparam int OVF_BIT = 3;
    localparam int UNF_BIT = 4;
    localparam int PRC_BIT = 5;
    localparam int EXC_W = 6;
    localparam int RND_LSB = 8;
    localparam logic [5:0] MASK_RESET = 6'h3F;
    localparam logic [1:0] RND_RESET = 2'h0;

    // Interrupt status bits
    localparam int IRQ_W = 2;
    localparam int IRQ_TRAP_BIT = 0;
    localparam int IRQ_FLAG_BIT = 1;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        RND_NEAREST = 2'h0,
        RND_DOWN = 2'h1,
        RND_UP = 2'h2,
        RND_ZERO = 2'h3
    } rnd_mode_e;

    // Winning condition class, higher priority first
    typedef enum logic [3:0] {
        WIN_NONE = 4'h0,
        WIN_STK_UNF = 4'h1,
        WIN_STK_OVF = 4'h2,
        WIN_UNSUP = 4'h3,
        WIN_SIG_NAN = 4'h4,
        WIN_QUIET_NAN = 4'h5,
        WIN_INV_OTHER = 4'h6,
        WIN_ZDIV = 4'h7,
        WIN_DENORM = 4'h8,
        WIN_OVF = 4'h9,
        WIN_UNF = 4'hA,
        WIN_PREC = 4'hB
    } win_e;

    // Result source chosen for the destination
    typedef enum logic [2:0] {
        RES_NONE = 3'h0,
        RES_ROUNDED = 3'h1,
        RES_QUIET_NOT_A_NUMBER = 3'h2,
        RES_INF = 3'h3,
        RES_MAXFIN = 3'h4,
        RES_DENORM = 3'h5,
        RES_BIASED = 3'h6
    } res_sel_e;

    // Operand-stage conditions (known before the operation)
    typedef struct packed {
        logic stack_unf;
        logic stack_ovf;
        logic unsup_fmt;
        logic signaling_not_a_number;
        logic quiet_not_a_number;
        logic inv_other;
        logic zero_div;
        logic denorm;
    } pre_cond_s;

    // Result-stage conditions (known from the unrounded result)
    typedef struct packed {
        logic overflow;
        logic tiny;
        logic inexact;
        logic sign;
    } post_cond_s;

    // Decision handed to the datapath and trap logic
    typedef struct packed {
        logic write_dest;
        res_sel_e res_sel;
        logic [EXC_W-1:0] flags_set;
        logic trap;
        win_e cause;
    } decision_s;

    // Trap sequencer states, Gray coded along the path
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_POST = 2'b01,
        ST_TRAP = 2'b11
    } seq_e;

endpackage

// *** hdl/fpx_pre_check.sv ***
// Operand-stage prioritizer: invalid, quiet NaN, zero divide, denormal
`timescale 1ns/1ps
module fpx_pre_check
    import fpx_pkg::*;
(
    input wire pre_cond_s cond_i,
    input wire logic stack_unit_i,
    input wire logic ext_fmt_i,
    input wire logic [EXC_W-1:0] mask_i,
    output win_e win_o,
    output logic [EXC_W-1:0] flags_o,
    output logic unmasked_o,
    output logic halt_o,
    output logic quiet_not_a_number_o
);
    logic stk_unf;
    logic stk_ovf;
    logic unsup;

    // Stack and format checks exist only in the stack unit
    assign stk_unf = cond_i.stack_unf & stack_unit_i;
    assign stk_ovf = cond_i.stack_ovf & stack_unit_i;
    assign unsup = cond_i.unsup_fmt & stack_unit_i & ext_fmt_i;

    always_comb begin
        win_o = WIN_NONE;
        flags_o = '0;
        unmasked_o = 1'b0;
        halt_o = 1'b0;
        quiet_not_a_number_o = 1'b0;
        // Fixed precedence, first hit wins
        if (stk_unf | stk_ovf | unsup | cond_i.signaling_not_a_number) begin
            win_o = stk_unf ? WIN_STK_UNF : stk_ovf ? WIN_STK_OVF :
                    unsup ? WIN_UNSUP : WIN_SIG_NAN;
            flags_o[INV_BIT] = 1'b1;
            unmasked_o = ~mask_i[INV_BIT];
            // Masked invalid returns quiet NaN, zero divide dropped
            quiet_not_a_number_o = mask_i[INV_BIT];
            halt_o = 1'b1;
        end else if (cond_i.quiet_not_a_number) begin
            // Not an exception, yet it hides everything below
            win_o = WIN_QUIET_NAN;
            quiet_not_a_number_o = 1'b1;
            halt_o = 1'b1;
        end else if (cond_i.inv_other | cond_i.zero_div) begin
            // Same level; invalid reported when both present
            win_o = cond_i.inv_other ? WIN_INV_OTHER : WIN_ZDIV;
            if (cond_i.inv_other) begin
                flags_o[INV_BIT] = 1'b1;
                unmasked_o = ~mask_i[INV_BIT];
                quiet_not_a_number_o = mask_i[INV_BIT];
            end else begin
                flags_o[ZDV_BIT] = 1'b1;
                unmasked_o = ~mask_i[ZDV_BIT];
            end
            halt_o = 1'b1;
        end else if (cond_i.denorm) begin
            win_o = WIN_DENORM;
            flags_o[DNR_BIT] = 1'b1;
            unmasked_o = ~mask_i[DNR_BIT];
            // Masked denormal lets the operation run on
            halt_o = ~mask_i[DNR_BIT];
        end
    end
endmodule

// *** hdl/fpx_post_check.sv ***
// Result-stage prioritizer: overflow, underflow, inexact
`timescale 1ns/1ps
module fpx_post_check
    import fpx_pkg::*;
(
    input wire post_cond_s cond_i,
    input wire logic [EXC_W-1:0] mask_i,
    input wire rnd_mode_e rnd_i,
    input wire logic stack_unit_i,
    output win_e win_o,
    output logic [EXC_W-1:0] flags_o,
    output logic unmasked_o,
    output logic write_o,
    output res_sel_e res_o
);
    always_comb begin
        win_o = WIN_NONE;
        flags_o = '0;
        unmasked_o = 1'b0;
        write_o = 1'b0;
        res_o = RES_NONE;
        // Judged only on the exact result
        if (cond_i.overflow) begin
            win_o = WIN_OVF;
            flags_o[OVF_BIT] = 1'b1;
            flags_o[PRC_BIT] = cond_i.inexact;
            unmasked_o = ~mask_i[OVF_BIT] | (cond_i.inexact & ~mask_i[PRC_BIT]);
            if (mask_i[OVF_BIT]) begin
                // Rounding mode and sign pick infinity or largest finite
                write_o = 1'b1;
                case (rnd_i)
                    RND_NEAREST: res_o = RES_INF;
                    RND_DOWN: res_o = cond_i.sign ? RES_INF : RES_MAXFIN;
                    RND_UP: res_o = cond_i.sign ? RES_MAXFIN : RES_INF;
                    default: res_o = RES_MAXFIN;
                endcase
            end else if (stack_unit_i) begin
                // Stack unit stores the biased result; packed units keep their destination
                write_o = 1'b1;
                res_o = RES_BIASED;
            end
        end else if (cond_i.tiny) begin
            win_o = WIN_UNF;
            if (mask_i[UNF_BIT]) begin
                // Flag only if tiny and inexact, denormal always stored
                flags_o[UNF_BIT] = cond_i.inexact;
                write_o = 1'b1;
                res_o = RES_DENORM;
            end else begin
                flags_o[UNF_BIT] = 1'b1;
                write_o = stack_unit_i;
                res_o = stack_unit_i ? RES_BIASED : RES_NONE;
            end
            flags_o[PRC_BIT] = cond_i.inexact;
            unmasked_o = ~mask_i[UNF_BIT] | (cond_i.inexact & ~mask_i[PRC_BIT]);
        end else if (cond_i.inexact) begin
            // Rounded result stored; trap only when unmasked
            win_o = WIN_PREC;
            flags_o[PRC_BIT] = 1'b1;
            unmasked_o = ~mask_i[PRC_BIT];
            write_o = 1'b1;
            res_o = RES_ROUNDED;
        end else begin
            write_o = 1'b1;
            res_o = RES_ROUNDED;
        end
        // Packed units never write once a trap is due
        if (unmasked_o && !stack_unit_i) begin
            write_o = 1'b0;
            res_o = RES_NONE;
        end
    end
endmodule

// *** hdl/fp_exception_prioritizer.sv ***
// Floating-point exception prioritizer with AHB-Lite register slave
// ----------------------------------------------------------------
// Functional notes
// - Several conditions from one instruction resolve by fixed precedence.
// - Masked signaling NaN over zero: invalid only, quiet NaN written.
// - Denormal or inexact with overflow/underflow handled too, not suppressed.
// - Invalid first: stack underflow, stack overflow, unsupported, signaling NaN.
// - Stack and format checks only in stack unit; format only extended.
// - Quiet NaN operand ranks second and hides lower conditions.
// - Other invalid and zero divide share third level.
// - Denormal fourth; masked, execution continues and lower ones may follow.
// - Overflow/underflow fifth with inexact; lone inexact sixth.
// - Invalid, zero divide, denormal found from operands before operating.
// - Overflow, underflow, inexact found only from the exact result.
// - Unmasked pre-operation condition leaves destination unwritten.
// - Unmasked post-operation: stack unit may write, packed units never.
// - Handler entry goes through the ordinary trap mechanism.
// - Masked overflow sets flag, returns infinity or largest finite.
// - Masked underflow flags tiny-and-inexact only; denormal always returned.
// - Lone inexact sets precision flag, stores rounded; trap if unmasked.
// ----------------------------------------------------------------
`timescale 1ns/1ps
module fp_exception_prioritizer
    import fpx_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Operand stage
    input wire logic pre_valid_i,
    input wire pre_cond_s pre_cond_i,
    input wire logic stack_unit_i,
    input wire logic ext_fmt_i,
    // Result stage
    input wire logic post_valid_i,
    input wire post_cond_s post_cond_i,
    // Decisions
    output logic pre_done_o,
    output logic proceed_o,
    output logic dec_valid_o,
    output decision_s dec_o,
    output logic trap_req_o,
    input wire logic trap_ack_i,
    output logic irq_o,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic hready_i
);
    // ----------------
    // Control registers and sub-checkers
    // ----------------
    logic unit_q, unit_d;
    logic [EXC_W-1:0] mask_q, mask_d;
    rnd_mode_e rnd_q, rnd_d;
    logic [EXC_W-1:0] flags_q, flags_d;
    logic [IRQ_W-1:0] ists_q, ists_d;
    logic [IRQ_W-1:0] imsk_q, imsk_d;
    decision_s last_q, last_d;

    win_e pre_win;
    logic [EXC_W-1:0] pre_flags;
    logic pre_unmasked;
    logic pre_halt;
    logic pre_quiet_not_a_number;

    win_e post_win;
    logic [EXC_W-1:0] post_flags;
    logic post_unmasked;
    logic post_write;
    res_sel_e post_res;

    fpx_pre_check u_pre (
        .cond_i(pre_cond_i),
        .stack_unit_i(stack_unit_i),
        .ext_fmt_i(ext_fmt_i),
        .mask_i(mask_q),
        .win_o(pre_win),
        .flags_o(pre_flags),
        .unmasked_o(pre_unmasked),
        .halt_o(pre_halt),
        .quiet_not_a_number_o(pre_quiet_not_a_number)
    );

    fpx_post_check u_post (
        .cond_i(post_cond_i),
        .mask_i(mask_q),
        .rnd_i(rnd_q),
        .stack_unit_i(unit_q),
        .win_o(post_win),
        .flags_o(post_flags),
        .unmasked_o(post_unmasked),
        .write_o(post_write),
        .res_o(post_res)
    );

    // ----------------
    // Instruction sequencer
    // ----------------
    seq_e st_q, st_d;
    win_e held_q, held_d;
    logic held_unm_q, held_unm_d;
    logic [EXC_W-1:0] held_flags_q, held_flags_d;
    logic pre_done_d, proceed_d, dec_valid_d;
    decision_s dec_d;
    logic [EXC_W-1:0] hw_flags;
    logic trap_evt;

    always_comb begin
        st_d = st_q;
        unit_d = unit_q;
        held_d = held_q;
        held_unm_d = held_unm_q;
        held_flags_d = held_flags_q;
        pre_done_d = 1'b0;
        proceed_d = 1'b0;
        dec_valid_d = 1'b0;
        dec_d = dec_o;
        hw_flags = '0;
        trap_evt = 1'b0;
        case (st_q)
            ST_IDLE: begin
                if (pre_valid_i) begin
                    pre_done_d = 1'b1;
                    unit_d = stack_unit_i;
                    hw_flags = pre_flags;
                    if (pre_halt) begin
                        // Pre-operation verdict closes the instruction
                        dec_valid_d = 1'b1;
                        dec_d.write_dest = ~pre_unmasked & pre_quiet_not_a_number;
                        dec_d.res_sel = dec_d.write_dest ? RES_QUIET_NOT_A_NUMBER : RES_NONE;
                        dec_d.flags_set = pre_flags;
                        dec_d.trap = pre_unmasked;
                        dec_d.cause = pre_win;
                        if (pre_unmasked) begin
                            st_d = ST_TRAP;
                        end
                    end else begin
                        proceed_d = 1'b1;
                        held_d = pre_win;
                        held_unm_d = 1'b0;
                        held_flags_d = pre_flags;
                        st_d = ST_POST;
                    end
                end
            end
            ST_POST: begin
                if (post_valid_i) begin
                    hw_flags = post_flags;
                    dec_valid_d = 1'b1;
                    dec_d.write_dest = post_write;
                    dec_d.res_sel = post_res;
                    // Masked denormal flag kept alongside result flags
                    dec_d.flags_set = post_flags | held_flags_q;
                    dec_d.trap = post_unmasked;
                    dec_d.cause = (post_win == WIN_NONE) ? held_q : post_win;
                    st_d = post_unmasked ? ST_TRAP : ST_IDLE;
                end
            end
            ST_TRAP: begin
                // Trap raised in the same cycle the flags land, held until taken
                if (trap_ack_i) begin
                    st_d = ST_IDLE;
                    trap_evt = 1'b1;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_q <= ST_IDLE;
            unit_q <= 1'b0;
            held_q <= WIN_NONE;
            held_unm_q <= 1'b0;
            held_flags_q <= '0;
            pre_done_o <= 1'b0;
            proceed_o <= 1'b0;
            dec_valid_o <= 1'b0;
            dec_o <= '0;
        end else begin
            st_q <= st_d;
            unit_q <= unit_d;
            held_q <= held_d;
            held_unm_q <= held_unm_d;
            held_flags_q <= held_flags_d;
            pre_done_o <= pre_done_d;
            proceed_o <= proceed_d;
            dec_valid_o <= dec_valid_d;
            dec_o <= dec_d;
        end
    end

    assign trap_req_o = (st_q == ST_TRAP);

    // ----------------
    // AHB-Lite slave, zero wait states
    // ----------------
    logic ap_wr_q, ap_wr_d;
    logic [7:0] ap_addr_q, ap_addr_d;
    logic [31:0] rdata_d;
    logic take;

    assign take = hsel_i & hready_i & htrans_i[1];
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    always_comb begin
        ap_wr_d = take & hwrite_i;
        ap_addr_d = take ? haddr_i[7:0] : ap_addr_q;
        rdata_d = '0;
        // Read in the address phase, shown in the data phase
        if (take & ~hwrite_i) begin
            case (haddr_i[7:0])
                CTRL_ADDR: rdata_d = {22'h0, rnd_q, 2'h0, mask_q};
                FLAGS_ADDR: rdata_d = {26'h0, flags_q};
                IRQ_STAT_ADDR: rdata_d = {30'h0, ists_q};
                IRQ_MASK_ADDR: rdata_d = {30'h0, imsk_q};
                LAST_ADDR: rdata_d = {17'h0, last_q};
                default: rdata_d = '0;
            endcase
        end
    end

    // ----------------
    // Flag, mask and interrupt registers
    // ----------------
    always_comb begin
        mask_d = mask_q;
        rnd_d = rnd_q;
        flags_d = flags_q;
        ists_d = ists_q;
        imsk_d = imsk_q;
        last_d = last_q;
        if (ap_wr_q) begin
            case (ap_addr_q)
                CTRL_ADDR: begin
                    mask_d = hwdata_i[EXC_W-1:0];
                    rnd_d = rnd_mode_e'(hwdata_i[RND_LSB+1:RND_LSB]);
                end
                // Flags are sticky; software clears by writing ones
                FLAGS_ADDR: flags_d = flags_q & ~hwdata_i[EXC_W-1:0];
                IRQ_STAT_ADDR: ists_d = ists_q & ~hwdata_i[IRQ_W-1:0];
                IRQ_MASK_ADDR: imsk_d = hwdata_i[IRQ_W-1:0];
                default: ;
            endcase
        end
        // Hardware sets win over a same-cycle clear
        flags_d = flags_d | hw_flags;
        if (trap_evt) begin
            ists_d[IRQ_TRAP_BIT] = 1'b1;
        end
        if (|hw_flags) begin
            ists_d[IRQ_FLAG_BIT] = 1'b1;
        end
        if (dec_valid_d) begin
            last_d = dec_d;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            mask_q <= MASK_RESET;
            rnd_q <= rnd_mode_e'(RND_RESET);
            flags_q <= '0;
            ists_q <= '0;
            imsk_q <= '0;
            last_q <= '0;
            ap_wr_q <= 1'b0;
            ap_addr_q <= '0;
            hrdata_o <= '0;
        end else begin
            mask_q <= mask_d;
            rnd_q <= rnd_d;
            flags_q <= flags_d;
            ists_q <= ists_d;
            imsk_q <= imsk_d;
            last_q <= last_d;
            ap_wr_q <= ap_wr_d;
            ap_addr_q <= ap_addr_d;
            hrdata_o <= rdata_d;
        end
    end

    assign irq_o = |(ists_q & imsk_q);
endmodule

// *** test/fpx_trap_model.sv ***
// Behavioural trap logic that acknowledges trap requests
`timescale 1ns/1ps
module fpx_trap_model (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic [2:0] lat_i,
    output logic ack_o
);
    logic [2:0] cnt_q;
    // One-cycle ack after a random delay
    always @(posedge ref_clk_i) begin
        if (rst_i || !req_i || ack_o) begin
            ack_o <= 1'b0;
            cnt_q <= 3'h0;
        end else if (cnt_q >= lat_i) begin
            ack_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 3'h1;
        end
    end
endmodule

// *** test/fpx_port_monitor.sv ***
// Port-level checker for the exception prioritizer
`timescale 1ns/1ps
module fpx_port_monitor import fpx_pkg::*; (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic pre_valid_i,
    input wire pre_cond_s pre_cond_i,
    input wire logic stack_unit_i,
    input wire logic post_valid_i,
    input wire logic pre_done_o,
    input wire logic proceed_o,
    input wire logic dec_valid_o,
    input wire decision_s dec_o,
    input wire logic trap_req_o,
    input wire logic trap_ack_i
);
    logic pk_q;
    // Unit kind comes only with the operands
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pk_q <= 1'b0;
        end else if (pre_valid_i) begin
            pk_q <= !stack_unit_i;
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    sequence trap_start;
        dec_valid_o && dec_o.trap;
    endsequence
    sequence quiet_not_a_number_in;
        pre_valid_i && pre_cond_i.quiet_not_a_number && pre_cond_i[7:4] == 4'h0;
    endsequence
    pre_answer_a: assert property (
        pre_valid_i |=> pre_done_o) else $error("no operand verdict");
    verdict_split_a: assert property (
        pre_done_o |-> proceed_o != dec_valid_o) else $error("proceed and verdict clash");
    post_answer_a: assert property (
        post_valid_i |=> dec_valid_o && !pre_done_o) else $error("no result verdict");
    trap_rise_a: assert property (
        trap_start |-> $rose(trap_req_o)) else $error("trap not raised with verdict");
    trap_cause_a: assert property (
        $rose(trap_req_o) |-> trap_start) else $error("trap without trapping verdict");
    trap_hold_a: assert property (
        trap_req_o && !trap_ack_i |=> trap_req_o) else $error("trap dropped early");
    trap_drop_a: assert property (
        trap_req_o && trap_ack_i |=> !trap_req_o) else $error("trap kept after ack");
    quiet_not_a_number_quiet_a: assert property (
        quiet_not_a_number_in |=> dec_valid_o && !dec_o.trap && dec_o.flags_set == 6'h00
            && dec_o.res_sel == RES_QUIET_NOT_A_NUMBER) else $error("quiet NaN not passed");
    packed_dest_a: assert property (
        dec_valid_o && !pre_done_o && dec_o.trap && pk_q |-> !dec_o.write_dest)
        else $error("packed unit wrote on trap");
    halt_dest_a: assert property (
        dec_valid_o && pre_done_o && dec_o.trap |-> !dec_o.write_dest)
        else $error("destination written on operand trap");
endmodule
bind fp_exception_prioritizer fpx_port_monitor u_mon (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .pre_valid_i(pre_valid_i),
    .pre_cond_i(pre_cond_i), .stack_unit_i(stack_unit_i), .post_valid_i(post_valid_i),
    .pre_done_o(pre_done_o), .proceed_o(proceed_o), .dec_valid_o(dec_valid_o),
    .dec_o(dec_o), .trap_req_o(trap_req_o), .trap_ack_i(trap_ack_i)
);

// *** test/fp_exception_prioritizer_test.sv ***
// Self-checking bench for the exception prioritizer
`timescale 1ns/1ps
module fp_exception_prioritizer_test import fpx_pkg::*;;
    typedef struct {decision_s e; logic [14:0] cr;} note_s;
    localparam logic [14:0] NOC = 15'h7FF0;
    localparam logic [14:0] NOR = 15'h47FF;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, pv = 1'b0, stk = 1'b0, ext = 1'b0, qv = 1'b0;
    pre_cond_s pc = '0;
    post_cond_s qc = '0;
    logic hsel = 1'b0, hwr = 1'b0, ack, done, go_on, dv_o, trq, irq, hrdy, hresp;
    logic [1:0] htr = 2'h0;
    logic [2:0] lat = 3'h0;
    logic [31:0] hadr = 32'h0, hwd = 32'h0, hrd, rs = 32'h32895A4F;
    decision_s dec;
    note_s expq[$];
    note_s nt;
    int fails = 0, n_compared = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    fp_exception_prioritizer dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .pre_valid_i(pv),
        .pre_cond_i(pc), .stack_unit_i(stk), .ext_fmt_i(ext), .post_valid_i(qv),
        .post_cond_i(qc), .pre_done_o(done), .proceed_o(go_on), .dec_valid_o(dv_o),
        .dec_o(dec), .trap_req_o(trq), .trap_ack_i(ack), .irq_o(irq), .hsel_i(hsel),
        .haddr_i(hadr), .htrans_i(htr), .hwrite_i(hwr), .hsize_i(3'h2), .hwdata_i(hwd),
        .hrdata_o(hrd), .hreadyout_o(hrdy), .hresp_o(hresp), .hready_i(hrdy));
    fpx_trap_model u_trap (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(trq),
        .lat_i(lat), .ack_o(ack));
    // ----------------
    // Helpers
    // ----------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic decision_s dv(logic w, res_sel_e r, logic [5:0] f, logic t, win_e c);
        return {w, r, f, t, c};
    endfunction
    task automatic chk(input logic [31:0] s, e);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r);
        int k;
        hsel <= 1'b1;
        htr <= 2'h2;
        hadr <= {24'h0, a};
        hwr <= w;
        k = 0;
        do begin @(posedge ref_clk_i); k++; end while (hrdy !== 1'b1 && k < 20);
        htr <= 2'h0;
        hsel <= 1'b0;
        hwd <= d;
        do begin @(posedge ref_clk_i); k++; end while (hrdy !== 1'b1 && k < 40);
        r = hrd;
        chk(hresp, 1'b0);
        if (k >= 40) begin fails++; finish_test(); end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        ahb(1'b0, a, 32'h0, v);
        chk(v, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        ahb(1'b1, a, d, v);
    endtask
    task automatic wait_irq(input logic e);
        int k;
        k = 0;
        while (irq !== e && k < 10) begin @(posedge ref_clk_i); k++; end
        chk(irq, e);
        if (k >= 10) finish_test();
    endtask
    // One instruction from masks to trap
    task automatic go(input logic [5:0] m, logic [1:0] rm, logic [7:0] p, logic st, ex, po,
            logic [3:0] q, decision_s e, logic [14:0] cr);
        int k;
        wr(CTRL_ADDR, {22'h0, rm, 2'h0, m});
        rs = xs(rs);
        lat <= rs[2:0];
        expq.push_back('{e, cr});
        pv <= 1'b1;
        pc <= p;
        stk <= st;
        ext <= ex;
        @(posedge ref_clk_i);
        pv <= 1'b0;
        @(posedge ref_clk_i);
        chk(go_on, po);
        if (po) begin
            qv <= 1'b1;
            qc <= q;
            @(posedge ref_clk_i);
            qv <= 1'b0;
        end
        k = 0;
        do begin @(posedge ref_clk_i); k++; end
        while ((expq.size() != 0 || trq !== 1'b0) && k < 100);
        if (k >= 100) begin fails++; finish_test(); end
    endtask
    // Match each verdict with the oldest note
    always @(posedge ref_clk_i) begin
        if (dv_o === 1'b1) begin
            if (expq.size() == 0) begin
                fails++;
                $display("ERROR %0t verdict without request", $time);
            end else begin
                nt = expq.pop_front();
                chk(32'(dec & nt.cr), 32'(nt.e & nt.cr));
            end
        end
    end
    // ----------------
    // Main sequence
    // ----------------
    initial begin
        res_sel_e ov;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 6; i++) rd(8'(4 * i), i == 0 ? 32'h3F : 32'h0);
        wr(IRQ_MASK_ADDR, 32'h1);
        go(6'h3E, 0, 8'hD0, 1, 0, 0, 0, dv(0, RES_NONE, 1, 1, WIN_STK_UNF), NOR);
        wait_irq(1'b1);
        wr(IRQ_STAT_ADDR, 32'h3);
        rd(IRQ_STAT_ADDR, 32'h0);
        wait_irq(1'b0);
        wr(IRQ_MASK_ADDR, 32'h0);
        go(6'h3F, 0, 8'h12, 1, 0, 0, 0, dv(1, RES_QUIET_NOT_A_NUMBER, 1, 0, WIN_NONE), NOC);
        go(6'h3F, 0, 8'h0A, 1, 0, 0, 0, dv(1, RES_QUIET_NOT_A_NUMBER, 0, 0, WIN_NONE), NOC);
        go(6'h3E, 0, 8'h70, 1, 1, 0, 0, dv(0, RES_NONE, 1, 1, WIN_STK_OVF), NOR);
        go(6'h3E, 0, 8'h30, 1, 1, 0, 0, dv(0, RES_NONE, 1, 1, WIN_UNSUP), NOR);
        go(6'h3E, 0, 8'h30, 1, 0, 0, 0, dv(0, RES_NONE, 1, 1, WIN_SIG_NAN), NOR);
        go(6'h3E, 0, 8'hD0, 0, 0, 0, 0, dv(0, RES_NONE, 1, 1, WIN_SIG_NAN), NOR);
        go(6'h3A, 0, 8'h06, 1, 0, 0, 0, dv(0, RES_NONE, 1, 1, WIN_INV_OTHER), NOR);
        go(6'h3B, 0, 8'h02, 1, 0, 0, 0, dv(0, RES_NONE, 4, 1, WIN_ZDIV), NOR);
        go(6'h3D, 0, 8'h01, 1, 0, 0, 0, dv(0, RES_NONE, 2, 1, WIN_DENORM), NOR);
        go(6'h3F, 0, 8'h01, 1, 0, 1, 4'hA, dv(1, RES_INF, 6'h2A, 0, WIN_NONE), NOC);
        for (int r = 0; r < 4; r++) begin
            for (int s = 0; s < 2; s++) begin
                ov = (r == 0 || (r == 1 && s == 1) || (r == 2 && s == 0)) ? RES_INF : RES_MAXFIN;
                go(6'h3F, 2'(r), 0, 1, 0, 1, {3'b100, 1'(s)}, dv(1, ov, 8, 0, WIN_NONE), NOC);
            end
        end
        go(6'h3F, 0, 0, 1, 0, 1, 4'h4, dv(1, RES_DENORM, 0, 0, WIN_NONE), NOC);
        go(6'h3F, 0, 0, 1, 0, 1, 4'h6, dv(1, RES_DENORM, 6'h30, 0, WIN_NONE), NOC);
        go(6'h3F, 0, 0, 0, 0, 1, {3'b001, rs[0]}, dv(1, RES_ROUNDED, 6'h20, 0, WIN_NONE), NOC);
        go(6'h1F, 0, 0, 1, 0, 1, 4'h2, dv(0, RES_NONE, 6'h20, 1, WIN_PREC), 15'h07FF);
        go(6'h37, 0, 0, 1, 0, 1, 4'h8, dv(1, RES_BIASED, 8, 1, WIN_OVF), 15'h7FFF);
        go(6'h37, 0, 0, 0, 0, 1, 4'h8, dv(0, RES_NONE, 8, 1, WIN_OVF), NOR);
        go(6'h2F, 0, 0, 0, 0, 1, 4'h4, dv(0, RES_NONE, 6'h10, 1, WIN_UNF), NOR);
        rd(IRQ_STAT_ADDR, 32'h3);
        wait_irq(1'b0);
        wr(IRQ_MASK_ADDR, 32'h2);
        wait_irq(1'b1);
        rd(FLAGS_ADDR, 32'h3F);
        wr(FLAGS_ADDR, 32'h3F);
        rd(FLAGS_ADDR, 32'h0);
        finish_test();
    end
endmodule
